// File: src/dmasr_pkg.sv
/*
  constants, carrier types and small helpers for the single dma channel
  with source reload and descriptor-linked destination.
  assumes nothing of its surroundings; every other file but the handshake module refers to it.
*/
package dmasr_pkg;
  // register byte addresses on the plain software port
  localparam logic [7:0] A_GEN   = 8'h00; // controller_global_enable
  localparam logic [7:0] A_CHER  = 8'h04; // channel_enable_set
  localparam logic [7:0] A_CHSR  = 8'h08; // channel_status
  localparam logic [7:0] A_ISR   = 8'h0C; // buffer_chain_irq_status
  localparam logic [7:0] A_SADDR = 8'h10; // chan_source_address
  localparam logic [7:0] A_DADDR = 8'h14; // chan_dest_address
  localparam logic [7:0] A_DSCR  = 8'h18; // chan_descriptor_pointer
  localparam logic [7:0] A_CTRLA = 8'h1C; // chan_control_word_a
  localparam logic [7:0] A_CTRLB = 8'h20; // chan_control_word_b
  localparam logic [7:0] A_CFG   = 8'h24; // chan_configuration
  localparam logic [7:0] A_SWREQ = 8'h28; // software handshake requests
  // field positions
  localparam int CA_DONE  = 31; // completion flag in control word a
  localparam int CB_AUTO  = 31; // reload/auto bit in control word b
  localparam int CB_SSTEP = 24; // source_address_step, 2 bits
  localparam int CB_DSTEP = 28; // dest_address_step, 2 bits
  localparam int CB_SIF   = 0;  // source_master_layer, 2 bits
  localparam int CB_DIF   = 4;  // dest_master_layer, 2 bits
  localparam int CFG_SPER = 0;  // source_peripheral_select, 4 bits
  localparam int CFG_DPER = 4;  // dest_peripheral_select, 4 bits
  localparam int CFG_SH2  = 9;  // source_hw_handshake_sel
  localparam int CFG_DH2  = 13; // dest_hw_handshake_sel
  localparam int ISR_BTC  = 0;  // buffer complete
  localparam int ISR_CBTC = 8;  // chained transfer complete
  // descriptor word offsets from the descriptor base
  localparam logic [2:0] D_SADDR = 3'h0;
  localparam logic [2:0] D_DADDR = 3'h1;
  localparam logic [2:0] D_CTRLA = 3'h2;
  localparam logic [2:0] D_CTRLB = 3'h3;
  localparam logic [2:0] D_NEXT  = 3'h4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // address step codes
  localparam logic [1:0] STEP_INC = 2'h0;
  localparam logic [1:0] STEP_DEC = 2'h1;

  // one memory command on the master port
  typedef struct packed {
    logic        we;
    logic [1:0]  layer;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmasr_mreq_t;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_FETCH = 5'h02,
    S_RD    = 5'h04,
    S_WR    = 5'h08,
    S_WB    = 5'h10
  } dmasr_state_t;

  // next word address for a given step code; other codes hold still
  function automatic logic [31:0] dmasr_step(input logic [31:0] a,
                                              input logic [1:0]  c);
    logic [31:0] r;
    r = a;
    if (c == STEP_INC)
      r = a + 32'h0000_0004;
    else if (c == STEP_DEC)
      r = a - 32'h0000_0004;
    return r;
  endfunction
endpackage

// File: src/dmasr_hs.sv
/*
  one side's request handshake: picks a peripheral request line or the
  software request bit and answers the chosen line with an ack pulse.
  assumes the requester holds its request until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
module dmasr_hs #(
  parameter int NPER = 16,
  parameter int PW   = 4
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic            hw_sel,
  input  wire logic [PW-1:0]   per_sel,
  input  wire logic [NPER-1:0] hw_req,
  input  wire logic            sw_req,
  input  wire logic            xfer_done,
  output logic                 go,
  output logic [NPER-1:0]      hw_ack
);
  // request seen by the engine: hardware line or software bit
  assign go = hw_sel ? hw_req[per_sel] : sw_req;

  // ack only the selected line, one cycle after the transaction ends
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hw_ack <= '0;
    else
    begin
      hw_ack <= '0;
      if (xfer_done && hw_sel)
        hw_ack[per_sel] <= 1'b1;
    end
  end
endmodule // dmasr_hs
`default_nettype wire

// File: src/dmasr_chan.sv
/*
  single dma channel: source address replayed after every buffer,
  destination, control words and next pointer loaded from a chain of
  descriptors in memory. registers on a plain strobe port.
  assumes a memory slave that answers mem_req with a one-cycle mem_ack
  and peripherals that hold a request until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
module dmasr_chan #(
  parameter int NPER = 16,
  parameter int PW   = 4
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  output logic                    mem_req,
  output dmasr_pkg::dmasr_mreq_t  mem_cmd,
  input  wire logic               mem_ack,
  input  wire logic [31:0]        mem_rdata,
  input  wire logic [NPER-1:0]    source_peripheral_select_req,
  input  wire logic [NPER-1:0]    dest_peripheral_select_req,
  output logic [NPER-1:0]         source_peripheral_select_ack,
  output logic [NPER-1:0]         dest_peripheral_select_ack
);
  dmasr_pkg::dmasr_state_t st;   // engine state
  logic        gen_en;           // controller_global_enable bit 0
  logic        chan_en;          // channel enable status
  logic [31:0] saddr;            // chan_source_address, live
  logic [31:0] saddr_init;       // value replayed after each buffer
  logic [31:0] daddr;            // chan_dest_address
  logic [31:0] dscr;             // chan_descriptor_pointer
  logic [31:0] ctrla;            // chan_control_word_a
  logic [31:0] ctrlb;            // chan_control_word_b
  logic [31:0] cfg;              // chan_configuration
  logic        isr_btc;          // buffer complete, sticky
  logic        isr_cbtc;         // chain complete, sticky
  logic        sw_src;           // software source request
  logic        sw_dst;           // software destination request
  logic [31:0] desc_base;        // current descriptor, its layer in [1:0]
  logic [2:0]  idx;              // descriptor word being fetched
  logic [15:0] moved;            // words moved in this buffer
  logic [31:0] data;             // word in flight

  // write decode, one strobe per writable register, plus the status read strobe
  wire w_gen   = reg_wr && (reg_addr == dmasr_pkg::A_GEN);
  wire w_cher  = reg_wr && (reg_addr == dmasr_pkg::A_CHER);
  wire w_saddr = reg_wr && (reg_addr == dmasr_pkg::A_SADDR);
  wire w_daddr = reg_wr && (reg_addr == dmasr_pkg::A_DADDR);
  wire w_dscr  = reg_wr && (reg_addr == dmasr_pkg::A_DSCR);
  wire w_ctrla = reg_wr && (reg_addr == dmasr_pkg::A_CTRLA);
  wire w_ctrlb = reg_wr && (reg_addr == dmasr_pkg::A_CTRLB);
  wire w_cfg   = reg_wr && (reg_addr == dmasr_pkg::A_CFG);
  wire w_swreq = reg_wr && (reg_addr == dmasr_pkg::A_SWREQ);
  wire r_isr   = reg_rd && (reg_addr == dmasr_pkg::A_ISR);

  // channel start: only from idle and with the controller enabled
  wire start = w_cher && reg_wdata[0] && gen_en
               && (st == dmasr_pkg::S_IDLE);

  wire src_go;                   // source side may move a word
  wire dst_go;                   // destination side may take it
  wire ack_rd = mem_req && mem_ack && (st == dmasr_pkg::S_RD);
  wire ack_wr = mem_req && mem_ack && (st == dmasr_pkg::S_WR);
  wire ack_fe = mem_req && mem_ack && (st == dmasr_pkg::S_FETCH);
  wire ack_wb = mem_req && mem_ack && (st == dmasr_pkg::S_WB);
  wire [15:0] moved_n = moved + 16'h0001;
  wire last_word = (moved_n == ctrla[15:0]);
  // terminating row: auto cleared and no next descriptor
  wire term = !ctrlb[dmasr_pkg::CB_AUTO]
              && (dscr[31:2] == 30'h0000_0000);
  // the layer bits stay with the base so write-back can reuse them
  wire [31:0] fetch_addr = {desc_base[31:2], 2'h0}
                           + {27'h000_0000, idx, 2'h0};
  // written-back word: size moved and completion flag set
  wire [31:0] wb_word = {1'b1, ctrla[30:16], moved};

  // read mux; unmapped addresses read zero
  wire [31:0] rd_mux =
    (reg_addr == dmasr_pkg::A_GEN)   ? {31'h0000_0000, gen_en}  :
    (reg_addr == dmasr_pkg::A_CHSR)  ? {31'h0000_0000, chan_en} :
    (reg_addr == dmasr_pkg::A_ISR)   ? {23'h00_0000, isr_cbtc,
                                        7'h00, isr_btc}        :
    (reg_addr == dmasr_pkg::A_SADDR) ? saddr :
    (reg_addr == dmasr_pkg::A_DADDR) ? daddr :
    (reg_addr == dmasr_pkg::A_DSCR)  ? dscr  :
    (reg_addr == dmasr_pkg::A_CTRLA) ? ctrla :
    (reg_addr == dmasr_pkg::A_CTRLB) ? ctrlb :
    (reg_addr == dmasr_pkg::A_CFG)   ? cfg   :
    (reg_addr == dmasr_pkg::A_SWREQ) ? {30'h0000_0000, sw_dst, sw_src} :
    dmasr_pkg::RST_WORD;

  // source and destination handshakes
  dmasr_hs #(.NPER(NPER), .PW(PW)) u_src (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .hw_sel    (cfg[dmasr_pkg::CFG_SH2]),
    .per_sel   (cfg[dmasr_pkg::CFG_SPER +: PW]),
    .hw_req    (source_peripheral_select_req),
    .sw_req    (sw_src),
    .xfer_done (ack_wr),
    .go        (src_go),
    .hw_ack    (source_peripheral_select_ack)
  );
  dmasr_hs #(.NPER(NPER), .PW(PW)) u_dst (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .hw_sel    (cfg[dmasr_pkg::CFG_DH2]),
    .per_sel   (cfg[dmasr_pkg::CFG_DPER +: PW]),
    .hw_req    (dest_peripheral_select_req),
    .sw_req    (sw_dst),
    .xfer_done (ack_wr),
    .go        (dst_go),
    .hw_ack    (dest_peripheral_select_ack)
  );

  // read data stand one cycle only; status read clears the flags
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= dmasr_pkg::RST_WORD;
      isr_btc   <= 1'b0;
      isr_cbtc  <= 1'b0;
      gen_en    <= 1'b0;
      cfg       <= dmasr_pkg::RST_WORD;
    end
    else
    begin
      reg_rdata <= reg_rd ? rd_mux : dmasr_pkg::RST_WORD;
      // a new event beats the clear of the same cycle
      isr_btc  <= (isr_btc && !r_isr) || ack_wb;
      isr_cbtc <= (isr_cbtc && !r_isr) || (ack_wb && term);
      if (w_gen)
        gen_en <= reg_wdata[0];
      if (w_cfg)
        cfg <= reg_wdata;
    end
  end

  // software requests: set by a write, dropped when the word moved
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_src <= 1'b0;
      sw_dst <= 1'b0;
    end
    else
    begin
      sw_src <= (sw_src && !ack_wr) || (w_swreq && reg_wdata[0]);
      sw_dst <= (sw_dst && !ack_wr) || (w_swreq && reg_wdata[1]);
    end
  end

  // engine: descriptor fetch, word moves, write-back, chaining
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st         <= dmasr_pkg::S_IDLE;
      chan_en    <= 1'b0;
      saddr      <= dmasr_pkg::RST_WORD;
      saddr_init <= dmasr_pkg::RST_WORD;
      daddr      <= dmasr_pkg::RST_WORD;
      dscr       <= dmasr_pkg::RST_WORD;
      ctrla      <= dmasr_pkg::RST_WORD;
      ctrlb      <= dmasr_pkg::RST_WORD;
      desc_base  <= dmasr_pkg::RST_WORD;
      idx        <= 3'h0;
      moved      <= 16'h0000;
      data       <= dmasr_pkg::RST_WORD;
      mem_req    <= 1'b0;
      mem_cmd    <= '0;
    end
    else
    begin
      // address, pointer and control word loads are ignored while the channel runs
      if (st == dmasr_pkg::S_IDLE)
      begin
        if (w_saddr)
        begin
          saddr      <= reg_wdata;
          saddr_init <= reg_wdata;
        end
        if (w_daddr)
          daddr <= reg_wdata;
        if (w_dscr)
          dscr <= reg_wdata;
        if (w_ctrla)
          ctrla <= reg_wdata;
        if (w_ctrlb)
          ctrlb <= reg_wdata;
      end
      if (mem_req && mem_ack)
        mem_req <= 1'b0;
      case (st)
        dmasr_pkg::S_IDLE:
        begin
          if (start)
          begin
            chan_en   <= 1'b1;
            desc_base <= dscr;
            idx       <= dmasr_pkg::D_SADDR;
            st        <= dmasr_pkg::S_FETCH;
          end
        end
        dmasr_pkg::S_FETCH:
        begin
          if (!mem_req)
          begin
            mem_req <= 1'b1;
            mem_cmd <= '{we: 1'b0, layer: desc_base[1:0],
                         addr: fetch_addr, wdata: dmasr_pkg::RST_WORD};
          end
          else if (mem_ack)
          begin
            // source word is read but dropped: the replay value rules
            case (idx)
              dmasr_pkg::D_DADDR: daddr <= mem_rdata;
              dmasr_pkg::D_CTRLA: ctrla <= mem_rdata;
              dmasr_pkg::D_CTRLB: ctrlb <= mem_rdata;
              dmasr_pkg::D_NEXT:  dscr  <= mem_rdata;
              default: ;
            endcase
            idx <= idx + 3'h1;
            if (idx == dmasr_pkg::D_NEXT)
            begin
              moved <= 16'h0000;
              // an empty buffer goes straight to write-back
              st <= (ctrla[15:0] == 16'h0000) ? dmasr_pkg::S_WB
                                             : dmasr_pkg::S_RD;
            end
          end
        end
        dmasr_pkg::S_RD:
        begin
          if (!mem_req && src_go)
          begin
            mem_req <= 1'b1;
            mem_cmd <= '{we: 1'b0,
                         layer: ctrlb[dmasr_pkg::CB_SIF +: 2],
                         addr: saddr, wdata: dmasr_pkg::RST_WORD};
          end
          else if (ack_rd)
          begin
            data <= mem_rdata;
            st   <= dmasr_pkg::S_WR;
          end
        end
        dmasr_pkg::S_WR:
        begin
          if (!mem_req && dst_go)
          begin
            mem_req <= 1'b1;
            mem_cmd <= '{we: 1'b1,
                         layer: ctrlb[dmasr_pkg::CB_DIF +: 2],
                         addr: daddr, wdata: data};
          end
          else if (ack_wr)
          begin
            moved <= moved_n;
            saddr <= dmasr_pkg::dmasr_step(saddr,
                       ctrlb[dmasr_pkg::CB_SSTEP +: 2]);
            daddr <= dmasr_pkg::dmasr_step(daddr,
                       ctrlb[dmasr_pkg::CB_DSTEP +: 2]);
            st <= last_word ? dmasr_pkg::S_WB : dmasr_pkg::S_RD;
          end
        end
        dmasr_pkg::S_WB:
        begin
          if (!mem_req)
          begin
            // only control word a goes back, on the descriptor layer
            mem_req <= 1'b1;
            // dscr already holds the next pointer here, so its layer
            // bits would be the wrong ones
            mem_cmd <= '{we: 1'b1, layer: desc_base[1:0],
                         addr: {desc_base[31:2], 2'h0} + 32'h0000_0008,
                         wdata: wb_word};
          end
          else if (mem_ack)
          begin
            ctrla <= wb_word;
            saddr <= saddr_init;
            if (term)
            begin
              chan_en <= 1'b0;
              st      <= dmasr_pkg::S_IDLE;
            end
            else
            begin
              desc_base <= dscr;
              idx       <= dmasr_pkg::D_SADDR;
              st        <= dmasr_pkg::S_FETCH;
            end
          end
        end
        default: st <= dmasr_pkg::S_IDLE;
      endcase
    end
  end

  // enable with the controller on starts a fetch next cycle
  property p_start;
    @(posedge ref_clk) disable iff (!rst_n)
    start |=> (st == dmasr_pkg::S_FETCH) && chan_en;
  endproperty
  a_start: assert property (p_start)
    else $error("channel did not start");

  // enable with the controller off is refused
  property p_no_start;
    @(posedge ref_clk) disable iff (!rst_n)
    (w_cher && !gen_en && st == dmasr_pkg::S_IDLE) |=>
      (st == dmasr_pkg::S_IDLE) && !chan_en;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("channel started while controller disabled");

  // first fetch reads the word at the programmed pointer
  property p_fetch0;
    @(posedge ref_clk) disable iff (!rst_n)
    start |-> ##2 mem_req && !mem_cmd.we
                  && mem_cmd.addr == {$past(desc_base[31:2]), 2'h0};
  endproperty
  a_fetch0: assert property (p_fetch0)
    else $error("first fetch address wrong");

  // reads use the replay source, never the fetched word
  property p_src;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(mem_req) && st == dmasr_pkg::S_RD |->
      mem_cmd.addr == $past(saddr) && $past(src_go);
  endproperty
  a_src: assert property (p_src)
    else $error("source read from wrong address");

  // write-back targets control word a with the flag set
  property p_wb;
    @(posedge ref_clk) disable iff (!rst_n)
    mem_req && st == dmasr_pkg::S_WB |->
      mem_cmd.we && mem_cmd.wdata[dmasr_pkg::CA_DONE]
      && mem_cmd.layer == desc_base[1:0]
      && mem_cmd.addr == {desc_base[31:2], 2'h0} + 32'h0000_0008;
  endproperty
  a_wb: assert property (p_wb)
    else $error("bad write-back");

  // buffer end restores the source and flags the buffer
  property p_reload;
    @(posedge ref_clk) disable iff (!rst_n)
    ack_wb |=> saddr == $past(saddr_init) && isr_btc;
  endproperty
  a_reload: assert property (p_reload)
    else $error("source not restored at buffer end");

  // terminating row stops the channel and flags the chain
  property p_term;
    @(posedge ref_clk) disable iff (!rst_n)
    ack_wb && term |=> !chan_en && isr_cbtc
                       && st == dmasr_pkg::S_IDLE;
  endproperty
  a_term: assert property (p_term)
    else $error("chain end not handled");

  // otherwise the next descriptor is fetched from the pointer
  property p_next;
    @(posedge ref_clk) disable iff (!rst_n)
    ack_wb && !term |=> st == dmasr_pkg::S_FETCH
      ##1 mem_req && mem_cmd.addr == {$past(dscr[31:2], 2), 2'h0};
  endproperty
  a_next: assert property (p_next)
    else $error("next descriptor not fetched");

  // a status read with no new event leaves the flags clear
  property p_clr;
    @(posedge ref_clk) disable iff (!rst_n)
    r_isr && !ack_wb |=> !isr_btc && !isr_cbtc;
  endproperty
  a_clr: assert property (p_clr)
    else $error("status read did not clear");
endmodule // dmasr_chan
`default_nettype wire

// File: verification/dmasr_mem_model.sv
/*
  memory slave model for the channel's master port: 256 words, one
  registered ack per request, prompt or with random wait states.
  assumes the bench preloads mem and reads it back by hierarchy.
*/
`timescale 1ns/1ps
`default_nettype none
module dmasr_mem_model (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   slow,
  input  wire logic                   mem_req,
  input  wire dmasr_pkg::dmasr_mreq_t mem_cmd,
  output logic                        mem_ack,
  output logic [31:0]                 mem_rdata
);
  logic [31:0] mem [256]; // word store
  logic [1:0]  lay [256]; // layer of the last write to each word
  int          wait_n;    // wait states left before the next answer
  wire  logic [7:0] idx = mem_cmd.addr[9:2];

  // answer once per request; data toggles when idle so stale data
  // never passes for a fresh read
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
      wait_n    <= 0;
    end
    else if (mem_req && !mem_ack && wait_n > 0)
      wait_n <= wait_n - 1;
    else if (mem_req && !mem_ack)
    begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem_cmd.we ? ~mem_rdata : mem[idx];
      wait_n    <= slow ? int'($urandom % 4) : 0;
      if (mem_cmd.we)
      begin
        mem[idx] <= mem_cmd.wdata;
        lay[idx] <= mem_cmd.layer;
      end
    end
    else
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // dmasr_mem_model
`default_nettype wire

// File: verification/dmasr_chan_tb.sv
/*
  self-checking bench for the dma channel: two-descriptor chains with
  each handshake mode, checked against a queue model of the data.
  assumes the memory model file is compiled before this one.
*/
`timescale 1ns/1ps
`default_nettype none
module dmasr_chan_tb;
  logic        ref_clk, rst_n, reg_wr, reg_rd, slow, mem_req, mem_ack;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, mem_rdata, rv;
  logic [15:0] source_peripheral_select_req, dest_peripheral_select_req, source_peripheral_select_ack, dest_peripheral_select_ack;
  logic [15:0] sel_mask; // the one line the channel listens on
  logic        hw_src;   // source side uses hardware handshake
  dmasr_pkg::dmasr_mreq_t mem_cmd;
  int          n_fail, cmp_count, ack_cnt, stray;
  logic [31:0] exp_q [$]; // model of the source buffer

  dmasr_chan u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .source_peripheral_select_req(source_peripheral_select_req),
    .dest_peripheral_select_req(dest_peripheral_select_req), .source_peripheral_select_ack(source_peripheral_select_ack),
    .dest_peripheral_select_ack(dest_peripheral_select_ack));
  dmasr_mem_model u_mem (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // count acks on the chosen line; any other ack line is an error
  always @(posedge ref_clk)
  begin
    ack_cnt += $countones((hw_src ? source_peripheral_select_ack : dest_peripheral_select_ack) & sel_mask);
    stray   += int'(((source_peripheral_select_ack | dest_peripheral_select_ack) & ~sel_mask) != 16'h0);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask

  // one chain: descriptor at 0x200 then the last one at 0x240
  task automatic run(input logic m);
    int n0, n1, p;
    logic [1:0] ly;
    n0 = $urandom_range(4, 1);
    n1 = $urandom_range(4, 1);
    p  = $urandom_range(15, 0);
    ly = 2'($urandom);
    sel_mask = 16'h1 << p;
    hw_src   = ~m;
    slow     <= m;
    ack_cnt  = 0;
    stray    = 0;
    exp_q.delete();
    // selected peripheral keeps requesting; noise on the others
    source_peripheral_select_req <= (16'($urandom) & ~sel_mask) | (m ? 16'h0 : sel_mask);
    dest_peripheral_select_req <= (16'($urandom) & ~sel_mask) | (m ? sel_mask : 16'h0);
    for (int i = 0; i < 8; i++)
    begin
      exp_q.push_back($urandom);
      u_mem.mem[64 + i]  = exp_q[i];
      u_mem.mem[224 + i] = ~exp_q[i]; // decoy behind the fetched word
      u_mem.mem[192 + i] = 32'h0;
      u_mem.mem[200 + i] = 32'h0;
    end
    u_mem.mem[128] = 32'h380;
    u_mem.mem[129] = 32'h300;
    u_mem.mem[130] = 32'(n0);
    u_mem.mem[131] = 32'h8000_0000;
    // second descriptor sits on another layer than the first
    u_mem.mem[132] = 32'h240 | 32'(ly ^ 2'h1);
    u_mem.mem[144] = 32'h380;
    u_mem.mem[145] = 32'h320;
    u_mem.mem[146] = 32'(n1);
    u_mem.mem[147] = 32'h0;
    u_mem.mem[148] = 32'(ly);
    reg_read(dmasr_pkg::A_ISR, rv);
    reg_read(dmasr_pkg::A_CHSR, rv);
    check(rv, 32'h0);
    reg_write(dmasr_pkg::A_SADDR, 32'h100);
    reg_write(dmasr_pkg::A_CFG, 32'((p << 4) | p | (m ? 32'h2000 : 32'h200)));
    reg_write(dmasr_pkg::A_DSCR, 32'h200 | 32'(ly));
    reg_write(dmasr_pkg::A_CHER, 32'h1);
    for (int k = 0; k < 400; k++)
    begin
      reg_write(dmasr_pkg::A_SWREQ, m ? 32'h1 : 32'h2);
      reg_read(dmasr_pkg::A_CHSR, rv);
      if (rv[0] === 1'b0)
        break;
    end
    check(rv, 32'h0);
    for (int i = 0; i < n0; i++)
      check(u_mem.mem[192 + i], exp_q[i]);
    for (int i = 0; i < n1; i++)
      check(u_mem.mem[200 + i], exp_q[i]);
    check(u_mem.mem[192 + n0], 32'h0);
    check(u_mem.mem[200 + n1], 32'h0);
    check(u_mem.mem[130], 32'h8000_0000 | 32'(n0));
    check(32'(u_mem.lay[130]), 32'(ly));
    check(u_mem.mem[146], 32'h8000_0000 | 32'(n1));
    check(32'(u_mem.lay[146]), 32'(ly ^ 2'h1));
    check(u_mem.mem[144], 32'h380);
    check(32'(ack_cnt), 32'(n0 + n1));
    check(32'(stray), 32'h0);
    reg_read(dmasr_pkg::A_ISR, rv);
    check(rv, 32'h101);
    reg_read(dmasr_pkg::A_ISR, rv);
    check(rv, 32'h0);
  endtask

  task automatic close_out;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // a hang is cut short well after both chains should have ended
  initial
  begin
    #(50 * 30000);
    n_fail++;
    close_out();
  end

  initial
  begin
    {rst_n, reg_wr, reg_rd, slow, hw_src} = 5'h0;
    {reg_addr, reg_wdata, source_peripheral_select_req, dest_peripheral_select_req, sel_mask} = 88'h0;
    void'($urandom(32'hB51F));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_write(dmasr_pkg::A_CHER, 32'h1); // refused while globally off
    reg_read(dmasr_pkg::A_CHSR, rv);
    check(rv, 32'h0);
    reg_read(8'h3C, rv);
    check(rv, 32'h0);
    reg_write(dmasr_pkg::A_GEN, 32'h1);
    reg_read(dmasr_pkg::A_GEN, rv);
    check(rv, 32'h1);
    run(1'b0);
    run(1'b1);
    close_out();
  end
endmodule // dmasr_chan_tb
`default_nettype wire
